// File: design/bstse_pkg.sv
// package for the bit set / bit test skip execute block
// assumes 12-bit instruction words and an 8-bit, 32-entry register file
package bstse_pkg;
	localparam int          INSN_W        = 12;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 5;
	localparam int          BIT_W         = 3;
	localparam int          OPC_MSB       = 11;
	localparam int          OPC_LSB       = 8;
	localparam int          BIT_MSB       = 7;
	localparam int          BIT_LSB       = 5;
	localparam int          ADDR_MSB      = 4;
	localparam int          ADDR_LSB      = 0;
	localparam logic [3:0]  OPC_SET_BIT   = 4'h5;
	localparam logic [3:0]  OPC_SKIP_CLR  = 4'h6;
	localparam logic [3:0]  OPC_SKIP_SET  = 4'h7;
	localparam logic [11:0] NOP_WORD      = 12'h000;
	localparam int          SKIP_CYCLES   = 2;

	typedef enum logic [2:0] {
		BSTSE_ST_RUN  = 3'b001,
		BSTSE_ST_READ = 3'b010,
		BSTSE_ST_KILL = 3'b100
	} bstse_state_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bstse_wr_t;
endpackage

// File: design/bstse_exec.sv
// decode and execute of set-bit and the two bit-test-and-skip instructions
// assumes the fetch stage presents one word per instruction cycle with a valid
// strobe, and the register file answers a read combinationally on the same cycle
`timescale 1ns/1ps
module bstse_exec (
	input  wire logic                         CLK_SYS_IN,
	input  wire logic                         RESET_N_IN,
	input  wire logic                         INSN_VALID_IN,
	input  wire logic [bstse_pkg::INSN_W-1:0] INSN_IN,
	input  wire logic [bstse_pkg::DATA_W-1:0] RD_DATA_IN,
	output logic      [bstse_pkg::ADDR_W-1:0] RD_ADDR_OUT,
	output logic                              WR_EN_OUT,
	output logic      [bstse_pkg::ADDR_W-1:0] WR_ADDR_OUT,
	output logic      [bstse_pkg::DATA_W-1:0] WR_DATA_OUT,
	output logic                              SKIP_OUT,
	output logic                              NOP_EXEC_OUT,
	output logic                              HANDLED_OUT
);
	// decoded fields shared by all three instructions
	logic [3:0]                        opc;
	logic [bstse_pkg::BIT_W-1:0]       bit_sel;
	logic [bstse_pkg::ADDR_W-1:0]      reg_addr;
	logic [bstse_pkg::DATA_W-1:0]      bit_hit;
	logic [bstse_pkg::DATA_W-1:0]      set_data;
	logic [bstse_pkg::DATA_W-1:0]      sel_and;
	logic                              sel_bit;

	// decode strobes
	logic                              take;
	logic                              kill;
	logic                              set_register_bit_op;
	logic                              skip_when_bit_clear_op;
	logic                              skip_when_bit_set_op;
	logic                              test_op;
	logic                              skip_now;

	// sequencing state
	bstse_pkg::bstse_state_t           state_r;
	bstse_pkg::bstse_state_t           state_nxt;

	// registered results
	bstse_pkg::bstse_wr_t              wr_r;
	bstse_pkg::bstse_wr_t              wr_nxt;
	logic                              skip_r;
	logic                              skip_nxt;
	logic                              nop_r;
	logic                              nop_nxt;
	logic                              hand_r;
	logic                              hand_nxt;

	assign opc      = INSN_IN[bstse_pkg::OPC_MSB:bstse_pkg::OPC_LSB];
	assign bit_sel  = INSN_IN[bstse_pkg::BIT_MSB:bstse_pkg::BIT_LSB];
	assign reg_addr = INSN_IN[bstse_pkg::ADDR_MSB:bstse_pkg::ADDR_LSB];

	// the file answers in the same cycle, so the read address is not registered
	assign RD_ADDR_OUT = reg_addr;

	// one lane per data bit: its hit, its set value and its share of the test
	for (genvar i = 0; i < bstse_pkg::DATA_W; i++) begin : g_lane
		localparam int LANE = i;

		assign bit_hit[i]  = (bit_sel == LANE[bstse_pkg::BIT_W-1:0]);
		assign set_data[i] = RD_DATA_IN[i] | bit_hit[i];
		assign sel_and[i]  = RD_DATA_IN[i] & bit_hit[i];
	end

	// exactly one lane hits, so the or of all lanes is the tested bit
	assign sel_bit = |sel_and;

	// while a kill is armed the word on the bus is the discarded prefetch
	assign kill = (state_r == bstse_pkg::BSTSE_ST_KILL);
	assign take = INSN_VALID_IN && !kill;

	always_comb begin
		set_register_bit_op    = 1'b0;
		skip_when_bit_clear_op = 1'b0;
		skip_when_bit_set_op   = 1'b0;
		if (take) begin
			case (opc)
				bstse_pkg::OPC_SET_BIT: begin
					set_register_bit_op = 1'b1;
				end
				bstse_pkg::OPC_SKIP_CLR: begin
					skip_when_bit_clear_op = 1'b1;
				end
				bstse_pkg::OPC_SKIP_SET: begin
					skip_when_bit_set_op = 1'b1;
				end
				default: begin
					// other opcodes belong to other execute units
					set_register_bit_op = 1'b0;
				end
			endcase
		end
	end

	// a test never reaches the write port, so registers and flags stay put
	assign test_op  = skip_when_bit_clear_op || skip_when_bit_set_op;
	assign skip_now = (skip_when_bit_clear_op && !sel_bit)
		|| (skip_when_bit_set_op && sel_bit);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bstse_pkg::BSTSE_ST_RUN: begin
				if (skip_now) begin
					state_nxt = bstse_pkg::BSTSE_ST_KILL;
				end else begin
					state_nxt = bstse_pkg::BSTSE_ST_RUN;
				end
			end
			bstse_pkg::BSTSE_ST_KILL: begin
				// a fetch stall keeps the kill armed so the skip still costs a cycle
				if (INSN_VALID_IN) begin
					state_nxt = bstse_pkg::BSTSE_ST_RUN;
				end else begin
					state_nxt = bstse_pkg::BSTSE_ST_KILL;
				end
			end
			default: begin
				// unused code: fall back to normal decode
				state_nxt = bstse_pkg::BSTSE_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_IN) begin
		// reset drops a pending kill: the first word after it is a fresh one
		if (!RESET_N_IN) begin
			state_r <= bstse_pkg::BSTSE_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// write lands one cycle late; a read of that register meanwhile is stale
	always_comb begin
		wr_nxt = '0;
		if (set_register_bit_op) begin
			wr_nxt.valid = 1'b1;
			wr_nxt.addr  = reg_addr;
			wr_nxt.data  = set_data;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			wr_r <= '0;
		end else begin
			wr_r <= wr_nxt;
		end
	end

	always_comb begin
		skip_nxt = 1'b0;
		if (skip_when_bit_clear_op && !sel_bit) begin
			skip_nxt = 1'b1;
		end
		if (skip_when_bit_set_op && sel_bit) begin
			skip_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= skip_nxt;
		end
	end

	// nop marks the dropped word, never a stall cycle
	always_comb begin
		nop_nxt = 1'b0;
		if (kill && INSN_VALID_IN) begin
			nop_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			nop_r <= 1'b0;
		end else begin
			nop_r <= nop_nxt;
		end
	end

	always_comb begin
		hand_nxt = 1'b0;
		if (set_register_bit_op) begin
			hand_nxt = 1'b1;
		end
		if (test_op) begin
			hand_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			hand_r <= 1'b0;
		end else begin
			hand_r <= hand_nxt;
		end
	end

	// every output but the read address comes straight from a register
	assign WR_EN_OUT    = wr_r.valid;
	assign WR_ADDR_OUT  = wr_r.addr;
	assign WR_DATA_OUT  = wr_r.data;
	assign SKIP_OUT     = skip_r;
	assign NOP_EXEC_OUT = nop_r;
	assign HANDLED_OUT  = hand_r;
endmodule

// File: tb/bstse_regfile.sv
// register file model: byte i starts as i; assumes writes land at the rising edge
`timescale 1ns/1ps
module bstse_regfile (input wire logic clk_in, we_in, input wire logic [4:0] wa_in, ra_in,
	input wire logic [7:0] wd_in, output logic [7:0] rd_out);
	logic [7:0] mem_r [32];
	initial for (int i = 0; i < 32; i++) mem_r[i] = 8'(i);
	always @(posedge clk_in) if (we_in) mem_r[wa_in] <= wd_in;
	assign rd_out = mem_r[ra_in];
endmodule

// File: tb/bstse_exec_checker.sv
// assertions at the exec ports; assumes one clock and sync active-low reset
`timescale 1ns/1ps
module bstse_chk (input wire logic CLK_SYS_IN, RESET_N_IN, INSN_VALID_IN, WR_EN_OUT, SKIP_OUT,
	input wire logic NOP_EXEC_OUT, HANDLED_OUT, input wire logic [11:0] INSN_IN,
	input wire logic [7:0] RD_DATA_IN, WR_DATA_OUT, input wire logic [4:0] WR_ADDR_OUT);
	logic      kill_r;
	wire       kill = SKIP_OUT | kill_r, drop = kill & INSN_VALID_IN, take = INSN_VALID_IN & ~kill;
	wire [3:0] op = INSN_IN[11:8];
	wire       set_op = take & (op == 4'h5), clr_op = take & (op == 4'h6), sst_op = take & (op == 4'h7);
	wire       bsel = RD_DATA_IN[INSN_IN[7:5]];
	wire [4:0] fa = INSN_IN[4:0];
	wire [7:0] set_v = RD_DATA_IN | (8'h01 << INSN_IN[7:5]);
	// a fetch stall after a skip keeps the kill armed
	always_ff @(posedge CLK_SYS_IN) kill_r <= RESET_N_IN & kill & ~INSN_VALID_IN;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESET_N_IN);
	chk_set_data: assert property (set_op |=> WR_DATA_OUT == $past(set_v)) else $error("set");
	chk_wr_addr: assert property (set_op |=> WR_EN_OUT && WR_ADDR_OUT == $past(fa)) else $error("wa");
	chk_clr_skip: assert property (clr_op |=> SKIP_OUT != $past(bsel)) else $error("clr");
	chk_set_skip: assert property (sst_op |=> SKIP_OUT == $past(bsel)) else $error("sst");
	chk_test_only: assert property (clr_op | sst_op |=> HANDLED_OUT & ~WR_EN_OUT) else $error("t");
	chk_kill_nop: assert property (drop |=> NOP_EXEC_OUT & ~HANDLED_OUT) else $error("nop");
	chk_nop_cause: assert property (NOP_EXEC_OUT |-> $past(drop)) else $error("stray nop");
	chk_wr_cause: assert property (WR_EN_OUT |-> $past(set_op)) else $error("stray write");
	cover property (set_op);
	cover property (kill_r & drop);
	cover property (drop);
	cover property (sst_op ##1 SKIP_OUT);
endmodule
bind bstse_exec bstse_chk i_bstse_chk (.*);

// File: tb/tb_bstse_exec.sv
// bench: words driven at the falling edge; assumes the register model answers reads at once
`timescale 1ns/1ps
module tb_bstse_exec;
	logic        CLK_SYS_IN = 1'b0, RESET_N_IN = 1'b0, INSN_VALID_IN = 1'b0;
	logic        WR_EN_OUT, SKIP_OUT, NOP_EXEC_OUT, HANDLED_OUT;
	logic [11:0] INSN_IN = 12'h000;
	logic [7:0]  RD_DATA_IN, WR_DATA_OUT;
	logic [4:0]  RD_ADDR_OUT, WR_ADDR_OUT;
	int          error_cnt = 0, n_checks = 0, cyc = 0;
	initial forever #2.5 CLK_SYS_IN = ~CLK_SYS_IN;
	bstse_exec i_bstse_exec (.CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
		.INSN_VALID_IN(INSN_VALID_IN), .INSN_IN(INSN_IN), .RD_DATA_IN(RD_DATA_IN),
		.RD_ADDR_OUT(RD_ADDR_OUT), .WR_EN_OUT(WR_EN_OUT), .WR_ADDR_OUT(WR_ADDR_OUT),
		.WR_DATA_OUT(WR_DATA_OUT), .SKIP_OUT(SKIP_OUT), .NOP_EXEC_OUT(NOP_EXEC_OUT),
		.HANDLED_OUT(HANDLED_OUT));
	bstse_regfile i_bstse_regfile (.clk_in(CLK_SYS_IN), .we_in(WR_EN_OUT), .wa_in(WR_ADDR_OUT),
		.wd_in(WR_DATA_OUT), .ra_in(RD_ADDR_OUT), .rd_out(RD_DATA_IN));
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", what, exp, got); end
	endtask
	task automatic step(logic v, logic [11:0] w);
		@(negedge CLK_SYS_IN);
		{INSN_VALID_IN, INSN_IN} = {v, w};
	endtask
	task automatic t_set(logic [2:0] b, logic [4:0] a);
		step(1'b1, {4'h5, b, a});
		step(1'b1, {4'h4, b ^ 3'h4, a}); // clear-bit of a set bit belongs elsewhere
		chk("set handled", 8'h01, {7'h00, HANDLED_OUT});
		step(1'b0, 12'h000);
		chk("other ignored", 8'h00, {6'h00, HANDLED_OUT, WR_EN_OUT});
		chk("set", 8'(a) | (8'h01 << b), i_bstse_regfile.mem_r[a]);
		$display("set test done");
	endtask
	task automatic t_skip(logic [3:0] op, logic [4:0] a, logic [2:0] k, logic sk);
		step(1'b1, {op, 3'h0, a});
		step(1'b1, {4'h5, k, 5'h00});
		chk("skip", {7'h00, sk}, {7'h00, SKIP_OUT});
		chk("test handled", 8'h01, {7'h00, HANDLED_OUT});
		step(1'b0, 12'h000);
		chk("nop", {7'h00, sk}, {7'h00, NOP_EXEC_OUT});
		chk("kill handled", {7'h00, ~sk}, {7'h00, HANDLED_OUT});
		step(1'b0, 12'h000);
		chk("kept", {7'h00, ~sk}, {7'h00, i_bstse_regfile.mem_r[0][k]});
		$display("skip test done");
	endtask
	task automatic t_stall;
		step(1'b1, {4'h7, 3'h0, 5'h03});
		step(1'b0, 12'h000);
		chk("stall skip", 8'h01, {7'h00, SKIP_OUT});
		step(1'b1, {4'h5, 3'h7, 5'h00});
		chk("stall no nop", 8'h00, {7'h00, NOP_EXEC_OUT});
		step(1'b0, 12'h000);
		chk("stall drop", 8'h02, {6'h00, NOP_EXEC_OUT, WR_EN_OUT});
		step(1'b0, 12'h000);
		chk("stall kept", 8'h00, {7'h00, i_bstse_regfile.mem_r[0][7]});
		$display("stall test done");
	endtask
	task automatic t_reset;
		step(1'b1, {4'h6, 3'h0, 5'h02});
		@(negedge CLK_SYS_IN);
		{RESET_N_IN, INSN_VALID_IN} = 2'b00;
		chk("rst skip", 8'h01, {7'h00, SKIP_OUT});
		@(negedge CLK_SYS_IN);
		RESET_N_IN = 1'b1;
		{INSN_VALID_IN, INSN_IN} = {1'b1, 4'h5, 3'h7, 5'h01};
		chk("rst clear", 8'h00, {6'h00, SKIP_OUT, NOP_EXEC_OUT});
		step(1'b0, 12'h000);
		chk("rst wr en", 8'h01, {7'h00, WR_EN_OUT});
		chk("rst wr data", 8'h81, WR_DATA_OUT);
		chk("rst wr addr", 8'h01, {3'h0, WR_ADDR_OUT});
		$display("reset test done");
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge CLK_SYS_IN) if (++cyc == 100) begin error_cnt++; report_and_stop(); end
	initial begin
		repeat (2) @(negedge CLK_SYS_IN);
		RESET_N_IN = 1'b1;
		t_set(3'h7, 5'h1F);
		for (int i = 0; i < 4; i++) t_skip(4'(6 + i / 2), 5'(2 + i % 2), 3'(i), (i / 2) == (i % 2));
		t_stall();
		t_reset();
		report_and_stop();
	end
endmodule
